// ---- include/vcs_pkg.sv ----
/*
  Constants and carrier types for the voice codec serial control block.
  Assumes one system clock of 25 MHz; all pin inputs are synchronised in the top module.
*/
// Summary of operation
// - Earpiece silence low disables the earphone amplifier output.
// - Receive channel goes to standby after frame sync low five frames.
// - Either frame sync high five frames enters production test mode.
// - Transmit channel goes to standby after frame sync low five frames.
// - Transmit frame sync handled independently, same timing as receive.
// - Coding select low means linear words, high means companded words.
// - Microphone silence low sends the zero code in every transmit slot.
// - Power-down low stops the block; it resumes when the pin returns high.
// - Fixed rate: shared pin is open-drain active-low transmit slot strobe.
// - Variable rate: shared pin is the transmit bit clock input.
// - Receive clock pin tied high selects fixed rate on the master clock.
// - Receive data sampled on falling edges of the receive bit clock.
// - Transmit data shifted out on rising edges of the transmit bit clock.
// - Linear words are 13 data plus 3 control bits; companded are 8.
package vcs_pkg;
  localparam int CLOCK_NS          = 40;
  localparam int RATE_HOLD_NS      = 2000;
  localparam int RATE_HOLD_CYCLES  = (RATE_HOLD_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int IDLE_FRAMES       = 5;
  localparam int FRAME_BITS_RESET  = 256;
  localparam logic [4:0] LIN_BITS  = 5'h10;
  localparam logic [4:0] COMP_BITS = 5'h08;
  localparam int LIN_DATA_BITS     = 13;
  localparam logic [7:0] MULAW_ZERO = 8'hff;
  localparam logic [7:0] ALAW_ZERO  = 8'hd5;
  localparam logic [15:0] LIN_ZERO  = 16'h0000;
  // Synchroniser lanes
  localparam int PIN_MCLK   = 0;
  localparam int PIN_RCLK   = 1;
  localparam int PIN_XCLK   = 2;
  localparam int PIN_RXFS   = 3;
  localparam int PIN_TXFS   = 4;
  localparam int PIN_DIN    = 5;
  localparam int PIN_MIC    = 6;
  localparam int PIN_EAR    = 7;
  localparam int PIN_CODING = 8;
  localparam int PIN_PDN    = 9;
  localparam int PIN_COUNT  = 10;
  // Channel index
  localparam int CH_RX = 0;
  localparam int CH_TX = 1;

  typedef struct packed {
    logic fixed_rate;
    logic companded;
    logic mic_silent;
    logic ear_silent;
    logic powered_down;
  } vcs_mode_type;

  typedef struct packed {
    logic standby;
    logic test_hold;
  } vcs_chan_type;
endpackage

// ---- src/vcs_top.sv ----
/*
  Serial control of a voice-band codec: rate detection, frame sync standby and
  test detection, serial word shift in and out, mute, coding and power-down.
  Assumes all pins are asynchronous to clock and the bit clocks run well below 1/4 of it.
*/
`timescale 1ns/1ns
module vcs_top #(
  parameter int FRAME_BITS  = vcs_pkg::FRAME_BITS_RESET,
  parameter bit ALAW_CODING = 1'b0
) (
  // System
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Serial link pins
  input  wire logic        master_clock,
  input  wire logic        rx_bit_clock_or_rate_select,
  input  wire logic        rx_frame_sync,
  input  wire logic        tx_frame_sync,
  input  wire logic        rx_data,
  output logic             tx_data,
  input  wire logic        tx_slot_strobe_or_clock_in,
  output logic             tx_slot_strobe_or_clock_out,
  output logic             tx_slot_strobe_or_clock_oe_n,
  // Control pins
  input  wire logic        mic_silence_n,
  input  wire logic        earpiece_silence_n,
  input  wire logic        coding_select,
  input  wire logic        power_down_n,
  // Converter side
  input  wire logic [15:0] tx_sample,
  input  wire logic [2:0]  tx_gain,
  output logic             tx_sample_taken,
  output logic [15:0]      rx_word,
  output logic             rx_word_valid,
  // Status
  output logic             ear_amp_enable,
  output logic             rx_standby,
  output logic             tx_standby,
  output logic             test_mode,
  output logic             powered_down,
  output logic             companded_mode,
  output logic             fixed_rate_mode
);
  logic [vcs_pkg::PIN_COUNT-1:0] sync1;
  logic [vcs_pkg::PIN_COUNT-1:0] sync2;
  logic [2:0]                    clk_prev;
  logic [7:0]                    rate_count;
  logic                          fixed_rate;
  vcs_pkg::vcs_mode_type         mode;
  vcs_pkg::vcs_chan_type         chan [2];
  logic [1:0]                    edge_hit;
  logic [1:0]                    fs_now;
  logic [1:0]                    fs_prev;
  logic [19:0]                   low_run [2];
  logic [19:0]                   high_run [2];
  logic [19:0]                   limit [2];

  wire [vcs_pkg::PIN_COUNT-1:0] pin_raw = {power_down_n, coding_select, earpiece_silence_n,
    mic_silence_n, rx_data, tx_frame_sync, rx_frame_sync, tx_slot_strobe_or_clock_in,
    rx_bit_clock_or_rate_select, master_clock};

  // Two flops before any logic; edges read only the second stage
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync1    <= '0;
      sync2    <= '0;
      clk_prev <= '0;
    end else begin
      sync1    <= pin_raw;
      sync2    <= sync1;
      clk_prev <= sync2[2:0];
    end
  end

  // Rate pin high for a whole hold window means tied high
  wire rate_pin_low = !sync2[vcs_pkg::PIN_RCLK];
  wire rate_full    = (rate_count == 8'(vcs_pkg::RATE_HOLD_CYCLES));
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rate_count <= '0;
      fixed_rate <= 1'b0;
    end else begin
      rate_count <= rate_pin_low ? 8'h00 : (rate_full ? rate_count : rate_count + 8'h01);
      fixed_rate <= rate_full;
    end
  end

  assign mode.fixed_rate   = fixed_rate;
  assign mode.companded    = sync2[vcs_pkg::PIN_CODING];
  assign mode.mic_silent   = !sync2[vcs_pkg::PIN_MIC];
  assign mode.ear_silent   = !sync2[vcs_pkg::PIN_EAR];
  assign mode.powered_down = !sync2[vcs_pkg::PIN_PDN];

  wire mclk_rise = sync2[vcs_pkg::PIN_MCLK] && !clk_prev[vcs_pkg::PIN_MCLK];
  wire mclk_fall = !sync2[vcs_pkg::PIN_MCLK] && clk_prev[vcs_pkg::PIN_MCLK];
  wire rclk_fall = !sync2[vcs_pkg::PIN_RCLK] && clk_prev[vcs_pkg::PIN_RCLK];
  wire xclk_rise = sync2[vcs_pkg::PIN_XCLK] && !clk_prev[vcs_pkg::PIN_XCLK];
  // Bit clock choice; the strobe pin is only a clock at variable rate
  assign edge_hit[vcs_pkg::CH_RX] = mode.fixed_rate ? mclk_fall : rclk_fall;
  assign edge_hit[vcs_pkg::CH_TX] = mode.fixed_rate ? mclk_rise : xclk_rise;
  assign fs_now = {sync2[vcs_pkg::PIN_TXFS], sync2[vcs_pkg::PIN_RXFS]};

  // One frame detector per channel, identical and independent
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic [15:0] period;
    logic [15:0] since_rise;
    wire         fs_rise = fs_now[ch] && !fs_prev[ch];
    // Saturating runs so a frame sync held still under a running bit clock cannot wrap a count back to zero
    wire  [15:0] next_since = &since_rise ? since_rise : since_rise + 16'h0001;
    wire  [19:0] next_low   = &low_run[ch] ? low_run[ch] : low_run[ch] + 20'h0_0001;
    wire  [19:0] next_high  = &high_run[ch] ? high_run[ch] : high_run[ch] + 20'h0_0001;
    assign limit[ch] = 20'(vcs_pkg::IDLE_FRAMES) * {4'h0, period};
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        period        <= 16'(FRAME_BITS);
        since_rise    <= '0;
        fs_prev[ch]   <= 1'b0;
        low_run[ch]   <= '0;
        high_run[ch]  <= '0;
        chan[ch]      <= '0;
      end else if (mode.powered_down) begin
        since_rise    <= '0;
        fs_prev[ch]   <= 1'b0;
        low_run[ch]   <= '0;
        high_run[ch]  <= '0;
        chan[ch]      <= '0;
      end else begin
        if (edge_hit[ch]) begin
          fs_prev[ch]  <= fs_now[ch];
          if (fs_rise && since_rise != 16'h0000) begin
            period     <= since_rise + 16'h0001;
          end
          since_rise   <= fs_rise ? 16'h0000 : next_since;
          low_run[ch]  <= fs_now[ch] ? 20'h0_0000 : next_low;
          high_run[ch] <= !fs_now[ch] ? 20'h0_0000 : next_high;
        end
        chan[ch].standby   <= (low_run[ch] >= limit[ch]);
        chan[ch].test_hold <= (high_run[ch] >= limit[ch]);
      end
    end
  end

  // Receive word assembly
  logic [15:0] rx_shift;
  logic [4:0]  rx_count;
  logic        rx_active;
  wire  [4:0]  word_bits = mode.companded ? vcs_pkg::COMP_BITS : vcs_pkg::LIN_BITS;
  wire         rx_start  = edge_hit[vcs_pkg::CH_RX] && !rx_active
                           && fs_now[vcs_pkg::CH_RX] && !fs_prev[vcs_pkg::CH_RX];
  wire         rx_done   = edge_hit[vcs_pkg::CH_RX] && rx_active
                           && (rx_count + 5'h01 == word_bits);
  wire  [15:0] rx_next   = {rx_shift[14:0], sync2[vcs_pkg::PIN_DIN]};
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_shift      <= '0;
      rx_count      <= '0;
      rx_active     <= 1'b0;
      rx_word       <= '0;
      rx_word_valid <= 1'b0;
    end else begin
      rx_word_valid <= 1'b0;
      if (mode.powered_down) begin
        rx_active     <= 1'b0;
      end else if (rx_start) begin
        // Fresh word drops old bits so a short word reads zero above
        rx_shift      <= {15'h0000, sync2[vcs_pkg::PIN_DIN]};
        rx_count      <= 5'h01;
        rx_active     <= 1'b1;
      end else if (rx_done) begin
        rx_active     <= 1'b0;
        rx_word       <= rx_next;
        rx_word_valid <= 1'b1;
      end else if (edge_hit[vcs_pkg::CH_RX] && rx_active) begin
        rx_shift      <= rx_next;
        rx_count      <= rx_count + 5'h01;
      end
    end
  end

  // Transmit word shifting
  logic [15:0] tx_shift;
  logic [4:0]  tx_count;
  logic        tx_active;
  wire  [7:0]  comp_zero = ALAW_CODING ? vcs_pkg::ALAW_ZERO : vcs_pkg::MULAW_ZERO;
  wire  [15:0] lin_load  = mode.mic_silent ? vcs_pkg::LIN_ZERO
                           : {tx_sample[vcs_pkg::LIN_DATA_BITS-1:0], tx_gain};
  wire  [15:0] comp_load = {(mode.mic_silent ? comp_zero : tx_sample[7:0]), 8'h00};
  wire  [15:0] tx_load   = mode.companded ? comp_load : lin_load;
  wire         tx_start  = edge_hit[vcs_pkg::CH_TX] && !tx_active
                           && fs_now[vcs_pkg::CH_TX] && !fs_prev[vcs_pkg::CH_TX];
  wire         tx_step   = edge_hit[vcs_pkg::CH_TX] && tx_active;
  wire         tx_end    = tx_step && (tx_count == word_bits);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_shift        <= '0;
      tx_count        <= '0;
      tx_active       <= 1'b0;
      tx_data         <= 1'b0;
      tx_sample_taken <= 1'b0;
    end else begin
      tx_sample_taken <= 1'b0;
      if (mode.powered_down) begin
        tx_active       <= 1'b0;
        tx_data         <= 1'b0;
      end else if (tx_start) begin
        tx_shift        <= {tx_load[14:0], 1'b0};
        tx_data         <= tx_load[15];
        tx_count        <= 5'h01;
        tx_active       <= 1'b1;
        tx_sample_taken <= 1'b1;
      end else if (tx_end) begin
        tx_active       <= 1'b0;
        tx_data         <= 1'b0;
      end else if (tx_step) begin
        tx_data         <= tx_shift[15];
        tx_shift        <= {tx_shift[14:0], 1'b0};
        tx_count        <= tx_count + 5'h01;
      end
    end
  end

  // Status and pin drive; the strobe pin only ever pulls low
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_slot_strobe_or_clock_out  <= 1'b0;
      tx_slot_strobe_or_clock_oe_n <= 1'b1;
      ear_amp_enable               <= 1'b0;
      rx_standby                   <= 1'b1;
      tx_standby                   <= 1'b1;
      test_mode                    <= 1'b0;
      powered_down                 <= 1'b0;
      companded_mode               <= 1'b0;
      fixed_rate_mode              <= 1'b0;
    end else begin
      tx_slot_strobe_or_clock_out  <= 1'b0;
      tx_slot_strobe_or_clock_oe_n <= mode.powered_down
                                      || !(mode.fixed_rate && tx_active && !tx_end
                                        || mode.fixed_rate && tx_start);
      ear_amp_enable               <= !mode.ear_silent && !mode.powered_down;
      rx_standby                   <= chan[vcs_pkg::CH_RX].standby || mode.powered_down;
      tx_standby                   <= chan[vcs_pkg::CH_TX].standby || mode.powered_down;
      test_mode                    <= chan[0].test_hold || chan[1].test_hold;
      powered_down                 <= mode.powered_down;
      companded_mode               <= mode.companded;
      fixed_rate_mode              <= mode.fixed_rate;
    end
  end

  chk_ear_silence: assert property (@(posedge clock) disable iff (!reset_n)
    mode.ear_silent |=> !ear_amp_enable) else $error("earphone amp on while silenced");
  chk_rx_standby: assert property (@(posedge clock) disable iff (!reset_n)
    (!mode.powered_down && low_run[0] >= limit[0]) |=> ##1 rx_standby)
    else $error("receive standby missed");
  chk_tx_standby: assert property (@(posedge clock) disable iff (!reset_n)
    (!mode.powered_down && low_run[1] >= limit[1]) |=> ##1 tx_standby)
    else $error("transmit standby missed");
  chk_test_entry: assert property (@(posedge clock) disable iff (!reset_n)
    (!mode.powered_down && (high_run[0] >= limit[0] || high_run[1] >= limit[1]))
    |=> ##1 test_mode) else $error("test mode missed");
  chk_mic_zero: assert property (@(posedge clock) disable iff (!reset_n)
    (tx_start && mode.mic_silent && !mode.companded && !mode.powered_down) |=> !tx_data)
    else $error("nonzero bit sent while mic silenced");
  chk_power_down: assert property (@(posedge clock) disable iff (!reset_n)
    mode.powered_down [*2] |-> powered_down && !tx_active && tx_slot_strobe_or_clock_oe_n)
    else $error("activity while powered down");
  chk_strobe_input: assert property (@(posedge clock) disable iff (!reset_n)
    !mode.fixed_rate |=> tx_slot_strobe_or_clock_oe_n)
    else $error("strobe pin driven at variable rate");
  chk_rx_word_len: assert property (@(posedge clock) disable iff (!reset_n)
    rx_word_valid |-> $past(rx_count) + 5'h01 == $past(word_bits))
    else $error("receive word length wrong");
endmodule

// ---- tb/vcs_dsp_model.sv ----
/*
  Controller model for the codec serial link: frame syncs, receive data,
  capture of transmit data and strobe. Assumes bit clocks copy master_clock.
*/
`timescale 1ns/1ns
module vcs_dsp_model #(
  parameter int FRAME_LEN = 32
) (
  // Link clock and commands
  input  wire logic        master_clock,
  input  wire logic        rx_enable,
  input  wire logic        tx_enable,
  input  wire logic        rx_hold_high,
  input  wire logic [4:0]  word_bits,
  input  wire logic [15:0] rx_word_send,
  // Link pins
  output logic             rx_frame_sync = 1'b0,
  output logic             tx_frame_sync = 1'b0,
  output logic             rx_data = 1'b0,
  input  wire logic        tx_data,
  input  wire logic        strobe_line,
  // Observation
  output logic [15:0]      tx_capture = 16'h0000,
  output logic             strobe_low = 1'b0,
  output logic [15:0]      frame_count = 16'h0000
);
  logic [4:0] bit_count  = 5'h00;
  wire  [4:0] next_count = (bit_count == 5'(FRAME_LEN - 1)) ? 5'h00 : bit_count + 5'h01;
  wire        in_slot    = next_count < word_bits;
  wire        in_capture = next_count != 5'h00 && next_count <= word_bits;
  wire  [3:0] bit_index  = 4'(word_bits - 5'h01 - next_count);
  // Change on rising edges; the device samples receive pins on falling ones and the transmit sync on rising ones
  always @(posedge master_clock) begin
    bit_count <= next_count;
    if (next_count == 5'h00) begin
      frame_count <= frame_count + 16'h0001;
    end
    rx_frame_sync <= rx_enable && (rx_hold_high || in_slot);
    tx_frame_sync <= tx_enable && in_slot;
    // Toggles outside the slot so stale bits cannot pass
    rx_data <= in_slot ? rx_word_send[bit_index] : !rx_data;
    if (in_capture) begin
      tx_capture <= {tx_capture[14:0], tx_data};
    end
    if (next_count == 5'h01) begin
      strobe_low <= !strobe_line;
    end
  end
endmodule

// ---- tb/vcs_top_tb.sv ----
/*
  Self-checking bench for the codec serial control block.
  Assumes the controller model vcs_dsp_model and a free-running master clock.
*/
`timescale 1ns/1ns
module vcs_top_tb;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        master_clock = 1'b0;
  logic        variable_rate = 1'b0;
  logic        mic_silence_n = 1'b1;
  logic        earpiece_silence_n = 1'b1;
  logic        coding_select = 1'b0;
  logic        power_down_n = 1'b1;
  logic [15:0] tx_sample = 16'h0000;
  logic [2:0]  tx_gain = 3'h0;
  logic        rx_enable = 1'b0;
  logic        tx_enable = 1'b0;
  logic        rx_hold_high = 1'b0;
  logic [4:0]  word_bits = vcs_pkg::LIN_BITS;
  logic [15:0] rx_word_send = 16'h0000;
  logic [31:0] seed = 32'h3214;
  int          err_count = 0;
  int          check_count = 0;
  int          taken_total = 0;
  int          valid_total = 0;
  wire         rx_frame_sync, tx_frame_sync, rx_data, tx_data, strobe_low;
  wire         tx_slot_strobe_or_clock_out, tx_slot_strobe_or_clock_oe_n;
  wire         ear_amp_enable, rx_standby, tx_standby, test_mode;
  wire         powered_down, companded_mode, fixed_rate_mode;
  wire         tx_sample_taken, rx_word_valid;
  wire  [15:0] rx_word, tx_capture, frame_count;
  // Pull-up on the open-drain strobe line
  wire strobe_line = tx_slot_strobe_or_clock_oe_n ? 1'b1 : tx_slot_strobe_or_clock_out;
  wire tx_slot_strobe_or_clock_in = variable_rate ? master_clock : strobe_line;
  wire rx_bit_clock_or_rate_select = variable_rate ? master_clock : 1'b1;

  always #20 clock = ~clock;
  // Odd start keeps master clock edges off the sampling edge
  initial begin
    #7;
    forever #160 master_clock = ~master_clock;
  end

  vcs_top #(.FRAME_BITS(32)) vcs_top_inst (
    .clock, .reset_n, .master_clock, .rx_bit_clock_or_rate_select,
    .rx_frame_sync, .tx_frame_sync, .rx_data, .tx_data,
    .tx_slot_strobe_or_clock_in, .tx_slot_strobe_or_clock_out,
    .tx_slot_strobe_or_clock_oe_n, .mic_silence_n, .earpiece_silence_n,
    .coding_select, .power_down_n, .tx_sample, .tx_gain, .tx_sample_taken,
    .rx_word, .rx_word_valid, .ear_amp_enable, .rx_standby, .tx_standby,
    .test_mode, .powered_down, .companded_mode, .fixed_rate_mode
  );

  vcs_dsp_model #(.FRAME_LEN(32)) vcs_dsp_model_inst (
    .master_clock, .rx_enable, .tx_enable, .rx_hold_high, .word_bits,
    .rx_word_send, .rx_frame_sync, .tx_frame_sync, .rx_data, .tx_data,
    .strobe_line, .tx_capture, .strobe_low, .frame_count
  );

  // Pulse tallies, read as differences so no task writes them
  always @(posedge clock) begin
    if (tx_sample_taken === 1'b1) begin
      taken_total <= taken_total + 1;
    end
    if (rx_word_valid === 1'b1) begin
      valid_total <= valid_total + 1;
    end
  end

  function automatic logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [15:0] exp_tx(logic [15:0] s, logic [2:0] g, logic comp, logic mic);
    if (!mic) begin
      return comp ? {8'h00, vcs_pkg::MULAW_ZERO} : vcs_pkg::LIN_ZERO;
    end
    return comp ? {8'h00, s[7:0]} : {s[12:0], g};
  endfunction

  function automatic logic [15:0] exp_rx(logic [15:0] w, logic comp);
    return comp ? {8'h00, w[7:0]} : w;
  endfunction

  task automatic check_bit(string what, logic expected, logic seen);
    check_count++;
    if (seen !== expected) begin
      err_count++;
      $display("unexpected %s: expected %b seen %b", what, expected, seen);
    end
  endtask

  task automatic check_word(string what, logic [15:0] expected, logic [15:0] seen);
    check_count++;
    if (seen !== expected) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, expected, seen);
    end
  endtask

  task automatic frames(int n);
    repeat (n) @(frame_count);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One configuration: rate, coding and mic mute from m, random data
  task automatic run_config(logic [2:0] m);
    logic [31:0] r;
    logic [15:0] cap;
    int          taken0;
    int          valid0;
    r = next_rand();
    @(posedge clock);
    variable_rate <= m[2];
    coding_select <= m[1];
    mic_silence_n <= m[0];
    earpiece_silence_n <= r[19];
    tx_sample <= r[15:0];
    tx_gain <= r[18:16];
    rx_word_send <= r[31:16];
    word_bits <= m[1] ? vcs_pkg::COMP_BITS : vcs_pkg::LIN_BITS;
    frames(2);
    taken0 = taken_total;
    valid0 = valid_total;
    frames(2);
    check_word("tx pulses", 16'h0002, 16'(taken_total - taken0));
    check_word("rx pulses", 16'h0002, 16'(valid_total - valid0));
    cap = m[1] ? {8'h00, tx_capture[7:0]} : tx_capture;
    check_word("tx word", exp_tx(r[15:0], r[18:16], m[1], m[0]), cap);
    check_word("rx word", exp_rx(r[31:16], m[1]), rx_word);
    check_bit("strobe", !m[2], strobe_low);
    check_bit("fixed rate", !m[2], fixed_rate_mode);
    check_bit("companded", m[1], companded_mode);
    check_bit("ear amp", r[19], ear_amp_enable);
  endtask

  initial begin
    repeat (60000) @(posedge clock);
    err_count++;
    conclude();
  end

  initial begin
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    repeat (60) @(posedge clock);
    rx_enable <= 1'b1;
    tx_enable <= 1'b1;
    for (int m = 0; m < 8; m++) begin
      run_config(3'(m));
    end
    @(posedge clock);
    rx_enable <= 1'b0;
    frames(3);
    check_bit("rx standby", 1'b0, rx_standby);
    frames(4);
    check_bit("rx standby", 1'b1, rx_standby);
    check_bit("tx standby", 1'b0, tx_standby);
    @(posedge clock);
    rx_enable <= 1'b1;
    tx_enable <= 1'b0;
    frames(7);
    check_bit("tx standby", 1'b1, tx_standby);
    check_bit("rx standby", 1'b0, rx_standby);
    @(posedge clock);
    tx_enable <= 1'b1;
    rx_hold_high <= 1'b1;
    frames(3);
    check_bit("test mode", 1'b0, test_mode);
    frames(4);
    check_bit("test mode", 1'b1, test_mode);
    @(posedge clock);
    rx_hold_high <= 1'b0;
    frames(3);
    check_bit("test mode", 1'b0, test_mode);
    @(posedge clock);
    power_down_n <= 1'b0;
    rx_word_send <= 16'ha5c3;
    repeat (10) @(posedge clock);
    check_bit("powered down", 1'b1, powered_down);
    check_bit("rx standby", 1'b1, rx_standby);
    @(posedge clock);
    power_down_n <= 1'b1;
    frames(4);
    check_bit("powered down", 1'b0, powered_down);
    check_bit("rx standby", 1'b0, rx_standby);
    check_word("rx word", exp_rx(16'ha5c3, 1'b1), rx_word);
    conclude();
  end
endmodule
